// [logic/drc_mem.sv]
// Small word store, one write port and one registered read port.
// Assumes both ports on pclk; contents are undefined until written.
`timescale 1ns/100ps
module drc_mem #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];
  // Array has no reset, kept small and cheap
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end
  // Read data one cycle after the address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata <= '0;
    else
      rdata <= mem[raddr];
  end
endmodule

// [logic/drc_req_done.sv]
// Request edge detect, busy tracking and done flag for one request bit.
// Assumes finish pulses once per start, and the master holds req until done.
`timescale 1ns/100ps
module drc_req_done (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic allow,
  input wire logic finish,
  output logic start,
  output logic busy,
  output logic done
);
  logic req_q;
  // A new rising edge starts work only when idle and done is cleared
  assign start = req && !req_q && allow && !busy && !done;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_q <= 1'b0;
    else
      req_q <= req;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy <= 1'b0;
    else if (start)
      busy <= 1'b1;
    else if (finish)
      busy <= 1'b0;
  end
  // Set wins over the clear by a released request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done <= 1'b0;
    else if (finish)
      done <= 1'b1;
    else if (!req)
      done <= 1'b0;
  end
  a_done_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(done) |-> $past(finish))
    else $error("done rose without finish");
  a_done_release: assert property (@(posedge pclk) disable iff (!presetn)
    done && !req && !finish |=> !done)
    else $error("done held after request release");
endmodule

// [logic/drc_top.sv]
// Remote command handler: APB registers, drive decode, setpoint writes,
// monitor refresh and instruction execution.
// Assumes one 200 MHz pclk; core ports answer with ack pulses on pclk.
`timescale 1ns/100ps
`include "drc_regs.svh"
module drc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0][15:0] mon_values,
  output drc_pkg::drc_drive_t drive,
  output logic [15:0] freq_cmd,
  output logic [15:0] torque_ram,
  output logic ee_req,
  output logic ee_sel,
  output logic [15:0] ee_data,
  input wire logic ee_ack,
  output logic instr_req,
  output logic [7:0] instr_code,
  output logic [7:0] instr_ext,
  output logic [15:0] instr_data,
  input wire logic instr_ack,
  input wire logic instr_err,
  input wire logic [15:0] instr_rdata
);
  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  drc_pkg::drc_remote_t cmd;
  drc_pkg::drc_cfg_t cfg;
  drc_pkg::drc_stat_t stat;
  logic [15:0] setp;
  logic [15:0] torq_word;
  logic [31:0] rd_q;
  logic sel_mem_q;
  logic in_wwin;
  logic in_rwin;
  logic reg_hit;
  logic ro_hit;
  logic bad;
  logic acc_wr;
  logic [15:0] rmem_rdata;
  logic [15:0] wmem_rdata;

  assign in_wwin = (paddr[11:7] == `DRC_WWIN_TAG);
  assign in_rwin = (paddr[11:7] == `DRC_RWIN_TAG);
  assign ro_hit = (paddr == `DRC_A_STAT) || (paddr == `DRC_A_FREQ);
  assign reg_hit = (paddr == `DRC_A_CMD) || (paddr == `DRC_A_SETP) ||
    (paddr == `DRC_A_TORQ) || (paddr == `DRC_A_CFG) || ro_hit;
  // Read-only words refuse writes rather than silently dropping them
  assign bad = !(reg_hit || in_wwin || in_rwin) || (pwrite && (ro_hit || in_rwin));
  assign pready = 1'b1;
  assign pslverr = psel && penable && bad;
  assign acc_wr = psel && penable && pwrite && !bad;

  // Software-written registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd <= `DRC_W16_RST;
      setp <= `DRC_W16_RST;
      torq_word <= `DRC_W16_RST;
      cfg <= `DRC_W16_RST;
    end
    else if (acc_wr)
    begin
      if (paddr == `DRC_A_CMD)
        cmd <= pwdata[15:0];
      if (paddr == `DRC_A_SETP)
        setp <= pwdata[15:0];
      if (paddr == `DRC_A_TORQ)
        torq_word <= pwdata[15:0];
      if (paddr == `DRC_A_CFG)
        cfg <= pwdata[15:0];
    end
  end

  // Read data captured in the setup cycle, zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_q <= '0;
      sel_mem_q <= 1'b0;
    end
    else if (psel && !penable)
    begin
      sel_mem_q <= in_rwin;
      unique case (paddr)
        `DRC_A_CMD: rd_q <= {16'h0000, cmd};
        `DRC_A_SETP: rd_q <= {16'h0000, setp};
        `DRC_A_TORQ: rd_q <= {16'h0000, torq_word};
        `DRC_A_CFG: rd_q <= {16'h0000, cfg};
        `DRC_A_STAT: rd_q <= {16'h0000, stat};
        `DRC_A_FREQ: rd_q <= {16'h0000, freq_cmd};
        default: rd_q <= '0;
      endcase
    end
  end
  assign prdata = sel_mem_q ? {16'h0000, rmem_rdata} : rd_q;

  // ----------------------------------------
  // Drive decode
  // ----------------------------------------
  // Registered so terminals never glitch on a partial command write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      drive <= '0;
    else
    begin
      if (cmd.forward_run_request && cmd.reverse_run_request)
        drive.run <= drc_pkg::DRC_STOP;
      else if (cmd.forward_run_request)
        drive.run <= drc_pkg::DRC_FWD;
      else if (cmd.reverse_run_request)
        drive.run <= drc_pkg::DRC_REV;
      else
        drive.run <= drc_pkg::DRC_STOP;
      drive.high_speed_terminal <= cmd.high_speed_bit;
      drive.middle_speed_terminal <= cmd.middle_speed_bit;
      drive.low_speed_terminal <= cmd.low_speed_bit;
      drive.jog_terminal <= cmd.jog_bit;
      drive.second_function_terminal <= cmd.second_function_bit;
      drive.current_input_terminal <= cmd.current_input_select_bit;
      drive.auto_restart_terminal <= cmd.auto_restart_select_bit;
      drive.output_shutoff_signal <=
        cmd.output_stop_request ^ cfg.output_stop_logic_param;
      drive.stop_hold_terminal <= cmd.self_holding_select_bit;
      drive.reset_terminal <= cmd.terminal_reset_bit;
    end
  end

  // ----------------------------------------
  // Request handshakes
  // ----------------------------------------
  logic basic;
  logic mon_start, mon_busy, mon_done, mon_wrap;
  logic vol_start, vol_busy, vol_done, vol_fin;
  logic nv_start, nv_busy, nv_done, nv_fin;
  logic ins_start, ins_busy, ins_done, ins_fin;

  // Basic profile: volatile beats nonvolatile beats instruction
  assign basic = (cfg.link_profile_param == `DRC_PROF_BASIC);

  drc_req_done u_mon (
    .pclk(pclk), .presetn(presetn), .req(cmd.monitor_request), .allow(1'b1),
    .finish(mon_wrap), .start(mon_start), .busy(mon_busy), .done(mon_done)
  );
  drc_req_done u_vol (
    .pclk(pclk), .presetn(presetn), .req(cmd.volatile_setpoint_write), .allow(1'b1),
    .finish(vol_fin), .start(vol_start), .busy(vol_busy), .done(vol_done)
  );
  drc_req_done u_nv (
    .pclk(pclk), .presetn(presetn), .req(cmd.nonvolatile_setpoint_write),
    .allow(!(basic && vol_start)),
    .finish(nv_fin), .start(nv_start), .busy(nv_busy), .done(nv_done)
  );
  drc_req_done u_ins (
    .pclk(pclk), .presetn(presetn), .req(cmd.instruction_execute_request),
    .allow(!(basic && (vol_start || nv_start))),
    .finish(ins_fin), .start(ins_start), .busy(ins_busy), .done(ins_done)
  );

  always_comb
  begin
    stat = '0;
    stat.monitor_done_flag = mon_done;
    stat.volatile_write_done_flag = vol_done;
    stat.nonvolatile_write_done_flag = nv_done;
    stat.instruction_done_flag = ins_done;
  end

  // ----------------------------------------
  // Setpoint writes
  // ----------------------------------------
  logic tq_vol_ok;
  logic tq_nv_ok;
  logic tq_nv_q;
  drc_pkg::drc_nv_st_t nv_st;

  assign tq_vol_ok = (cfg.method != drc_pkg::DRC_VF);
  assign tq_nv_ok = tq_vol_ok && ((cfg.mode == drc_pkg::DRC_TORQUE) ||
    ((cfg.link_profile_param != `DRC_PROF_TQA) &&
     (cfg.link_profile_param != `DRC_PROF_TQB)));

  // RAM copy; a held volatile request keeps the setpoint applied
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      freq_cmd <= `DRC_W16_RST;
    else if (vol_start || nv_start)
      freq_cmd <= setp;
    else if (cmd.volatile_setpoint_write && (vol_busy || vol_done))
      freq_cmd <= setp;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      torque_ram <= `DRC_W16_RST;
    else if ((vol_start && tq_vol_ok) || (nv_start && tq_nv_ok))
      torque_ram <= torq_word;
  end
  // RAM write completes at once, done follows next edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vol_fin <= 1'b0;
    else
      vol_fin <= vol_start;
  end

  // EEPROM sequencer; frequency first, then torque when it applies
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nv_st <= drc_pkg::DRC_N_IDLE;
      ee_data <= `DRC_W16_RST;
      tq_nv_q <= 1'b0;
    end
    else
    begin
      unique case (nv_st)
        drc_pkg::DRC_N_IDLE:
          if (nv_start)
          begin
            nv_st <= drc_pkg::DRC_N_FREQ;
            ee_data <= setp;
            tq_nv_q <= tq_nv_ok;
          end
        drc_pkg::DRC_N_FREQ:
          if (ee_ack && tq_nv_q)
          begin
            nv_st <= drc_pkg::DRC_N_TORQ;
            ee_data <= torq_word;
          end
          else if (ee_ack)
            nv_st <= drc_pkg::DRC_N_IDLE;
        drc_pkg::DRC_N_TORQ:
          if (ee_ack)
            nv_st <= drc_pkg::DRC_N_IDLE;
        default:
          nv_st <= drc_pkg::DRC_N_IDLE;
      endcase
    end
  end
  assign ee_req = (nv_st != drc_pkg::DRC_N_IDLE);
  assign ee_sel = (nv_st == drc_pkg::DRC_N_TORQ);
  // Done only after the last EEPROM word is acknowledged
  assign nv_fin = ee_ack && (ee_sel || ((nv_st == drc_pkg::DRC_N_FREQ) && !tq_nv_q));

  // ----------------------------------------
  // Instruction execution
  // ----------------------------------------
  drc_pkg::drc_ins_st_t ins_st;
  logic [2:0] slot;
  logic [2:0] slot_m1;
  logic [4:0] iw_idx;
  logic [4:0] wmem_raddr;
  logic [15:0] reply;
  logic [15:0] rdat;
  logic ins_wr;

  // Slot 0 is word 2, the rest pair up from word 0x10
  assign slot_m1 = slot - 3'h1;
  assign iw_idx = (slot == `DRC_SLOT_FIRST) ? `DRC_IW_FIRST :
    (`DRC_IW_EXT + {1'b0, slot_m1, 1'b0});
  assign wmem_raddr = (ins_st == drc_pkg::DRC_I_CODE) ? (iw_idx + 5'h01) : iw_idx;
  assign ins_wr = (ins_st == drc_pkg::DRC_I_REPLY) || (ins_st == drc_pkg::DRC_I_RDATA);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ins_st <= drc_pkg::DRC_I_IDLE;
      slot <= `DRC_SLOT_FIRST;
      instr_code <= '0;
      instr_ext <= '0;
      instr_data <= '0;
      reply <= `DRC_REPLY_OK;
      rdat <= '0;
    end
    else
    begin
      unique case (ins_st)
        drc_pkg::DRC_I_IDLE:
          if (ins_start)
          begin
            ins_st <= drc_pkg::DRC_I_FETCH;
            slot <= `DRC_SLOT_FIRST;
          end
        drc_pkg::DRC_I_FETCH:
          ins_st <= drc_pkg::DRC_I_CODE;
        drc_pkg::DRC_I_CODE:
        begin
          instr_code <= wmem_rdata[7:0];
          instr_ext <= wmem_rdata[15:8];
          ins_st <= drc_pkg::DRC_I_DATA;
        end
        drc_pkg::DRC_I_DATA:
        begin
          instr_data <= wmem_rdata;
          ins_st <= drc_pkg::DRC_I_ISSUE;
        end
        drc_pkg::DRC_I_ISSUE:
          if (instr_ack)
          begin
            reply <= instr_err ? `DRC_REPLY_ERR : `DRC_REPLY_OK;
            rdat <= instr_rdata;
            ins_st <= drc_pkg::DRC_I_REPLY;
          end
        drc_pkg::DRC_I_REPLY:
          ins_st <= drc_pkg::DRC_I_RDATA;
        drc_pkg::DRC_I_RDATA:
          if (slot == `DRC_SLOT_LAST)
            ins_st <= drc_pkg::DRC_I_IDLE;
          else
          begin
            slot <= slot + 3'h1;
            ins_st <= drc_pkg::DRC_I_FETCH;
          end
        default:
          ins_st <= drc_pkg::DRC_I_IDLE;
      endcase
    end
  end
  assign instr_req = (ins_st == drc_pkg::DRC_I_ISSUE);
  // All six slots written back before done
  assign ins_fin = (ins_st == drc_pkg::DRC_I_RDATA) && (slot == `DRC_SLOT_LAST);

  // ----------------------------------------
  // Monitor refresh and word stores
  // ----------------------------------------
  logic [2:0] mon_slot;
  logic [4:0] mon_idx;
  logic rmem_we;
  logic [4:0] rmem_waddr;
  logic [15:0] rmem_wdata;

  // Monitor words 0, 1, then 4 to 7
  assign mon_idx = (mon_slot < `DRC_MON_SPLIT) ? {2'b00, mon_slot} :
    ({2'b00, mon_slot} + `DRC_MON_GAP);
  // Instruction write-back steals the port; monitor just waits its two cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mon_slot <= `DRC_SLOT_FIRST;
    else if (!cmd.monitor_request)
      mon_slot <= `DRC_SLOT_FIRST;
    else if (!ins_wr)
      mon_slot <= (mon_slot == `DRC_SLOT_LAST) ? `DRC_SLOT_FIRST : (mon_slot + 3'h1);
  end
  assign mon_wrap = cmd.monitor_request && !ins_wr && (mon_slot == `DRC_SLOT_LAST)
    && mon_busy;

  always_comb
  begin
    rmem_we = 1'b0;
    rmem_waddr = mon_idx;
    rmem_wdata = mon_values[mon_slot];
    if (ins_st == drc_pkg::DRC_I_REPLY)
    begin
      rmem_we = 1'b1;
      rmem_waddr = iw_idx;
      rmem_wdata = reply;
    end
    else if (ins_st == drc_pkg::DRC_I_RDATA)
    begin
      rmem_we = 1'b1;
      rmem_waddr = iw_idx + 5'h01;
      rmem_wdata = rdat;
    end
    else if (cmd.monitor_request)
      rmem_we = 1'b1;
  end

  drc_mem u_rmem (
    .pclk(pclk), .presetn(presetn), .we(rmem_we), .waddr(rmem_waddr),
    .wdata(rmem_wdata), .raddr(paddr[6:2]), .rdata(rmem_rdata)
  );
  drc_mem u_wmem (
    .pclk(pclk), .presetn(presetn), .we(acc_wr && in_wwin), .waddr(paddr[6:2]),
    .wdata(pwdata[15:0]), .raddr(wmem_raddr), .rdata(wmem_rdata)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_both_stop: assert property (
    cmd.forward_run_request && cmd.reverse_run_request |=> drive.run == drc_pkg::DRC_STOP)
    else $error("both run bits did not stop");
  a_fwd_start: assert property (
    cmd.forward_run_request && !cmd.reverse_run_request |=> drive.run == drc_pkg::DRC_FWD)
    else $error("forward not started");
  a_rev_start: assert property (
    !cmd.forward_run_request && cmd.reverse_run_request |=> drive.run == drc_pkg::DRC_REV)
    else $error("reverse not started");
  a_shutoff_active: assert property (
    cmd.output_stop_request && !cfg.output_stop_logic_param |=> drive.output_shutoff_signal)
    else $error("shutoff not driven");
  a_vol_done_time: assert property (
    vol_start && cmd.volatile_setpoint_write |=> vol_fin ##1 vol_done)
    else $error("volatile done late");
  a_vol_hold_freq: assert property (
    cmd.volatile_setpoint_write && vol_done |=> freq_cmd == $past(setp))
    else $error("held setpoint not applied");
  a_basic_single: assert property (
    basic && vol_start |-> !nv_start && !ins_start)
    else $error("two requests started in basic profile");
  a_nv_after_ee: assert property (
    $rose(nv_done) |-> $past(ee_ack))
    else $error("nonvolatile done before eeprom ack");
  a_err_reply: assert property (
    instr_req && instr_ack && instr_err |=> rmem_we && rmem_wdata != `DRC_REPLY_OK)
    else $error("error reply is zero");
  a_mon_last_word: assert property (
    $rose(mon_done) |-> $past(rmem_waddr) == 5'h07)
    else $error("monitor done before sweep end");
endmodule

// [pkg/drc_pkg.sv]
// Types shared by the remote command handler files.
// Assumes field positions are fixed by the packed struct order below.
package drc_pkg;
  // Remote request bits, bit 0 at the bottom
  typedef struct packed {
    logic instruction_execute_request;
    logic nonvolatile_setpoint_write;
    logic volatile_setpoint_write;
    logic monitor_request;
    logic terminal_reset_bit;
    logic self_holding_select_bit;
    logic output_stop_request;
    logic auto_restart_select_bit;
    logic current_input_select_bit;
    logic second_function_bit;
    logic jog_bit;
    logic low_speed_bit;
    logic middle_speed_bit;
    logic high_speed_bit;
    logic reverse_run_request;
    logic forward_run_request;
  } drc_remote_t;
  typedef enum logic [1:0] {DRC_VF, DRC_SENSORLESS, DRC_VECTOR, DRC_PM} drc_method_t;
  typedef enum logic [1:0] {DRC_SPEED, DRC_POSITION, DRC_TORQUE, DRC_MODE_RSV} drc_mode_t;
  typedef struct packed {
    logic [7:0] link_profile_param;
    logic [2:0] rsv;
    drc_mode_t mode;
    drc_method_t method;
    logic output_stop_logic_param;
  } drc_cfg_t;
  typedef struct packed {
    logic [11:0] rsv;
    logic instruction_done_flag;
    logic nonvolatile_write_done_flag;
    logic volatile_write_done_flag;
    logic monitor_done_flag;
  } drc_stat_t;
  typedef enum logic [1:0] {DRC_STOP, DRC_FWD, DRC_REV} drc_run_t;
  typedef struct packed {
    drc_run_t run;
    logic high_speed_terminal;
    logic middle_speed_terminal;
    logic low_speed_terminal;
    logic jog_terminal;
    logic second_function_terminal;
    logic current_input_terminal;
    logic auto_restart_terminal;
    logic output_shutoff_signal;
    logic stop_hold_terminal;
    logic reset_terminal;
  } drc_drive_t;
  typedef enum logic [1:0] {DRC_N_IDLE, DRC_N_FREQ, DRC_N_TORQ} drc_nv_st_t;
  typedef enum logic [2:0] {
    DRC_I_IDLE, DRC_I_FETCH, DRC_I_CODE, DRC_I_DATA, DRC_I_ISSUE, DRC_I_REPLY, DRC_I_RDATA
  } drc_ins_st_t;
endpackage

// [pkg/drc_regs.svh]
// Register offsets, window tags and fixed codes of the remote command handler.
// Assumes byte addressing on a 12-bit APB address, one 32-bit word per register.
`ifndef DRC_REGS_SVH
`define DRC_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DRC_A_CMD 12'h000
`define DRC_A_SETP 12'h004
`define DRC_A_TORQ 12'h008
`define DRC_A_CFG 12'h00c
`define DRC_A_STAT 12'h010
`define DRC_A_FREQ 12'h014
// Word windows, tag is paddr[11:7]
`define DRC_WWIN_TAG 5'h02
`define DRC_RWIN_TAG 5'h04
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define DRC_W16_RST 16'h0000
`define DRC_PROF_BASIC 8'h00
`define DRC_PROF_TQA 8'h18
`define DRC_PROF_TQB 8'h1c
`define DRC_REPLY_OK 16'h0000
`define DRC_REPLY_ERR 16'h0001
`define DRC_SLOT_FIRST 3'h0
`define DRC_SLOT_LAST 3'h5
`define DRC_IW_FIRST 5'h02
`define DRC_IW_EXT 5'h10
`define DRC_MON_SPLIT 3'h2
`define DRC_MON_GAP 5'h02
`endif

// [tb/drc_core_model.sv]
// Core side model: EEPROM store port and instruction executor.
// Assumes each request holds until acked; dly sets the wait before each ack.
`timescale 1ns/100ps
module drc_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] dly,
  input wire logic ee_req,
  input wire logic instr_req,
  input wire logic [7:0] instr_code,
  output logic ee_ack,
  output logic [3:0] ee_count,
  output logic instr_ack,
  output logic instr_err,
  output logic [15:0] instr_rdata
);
  // ----------------------------------------
  // Answers
  // ----------------------------------------
  logic [2:0] ec;
  logic [2:0] ic;
  // Store port; ack drops for a cycle so one store is never acked twice
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ee_ack <= 1'b0;
      ec <= 3'h0;
      ee_count <= 4'h0;
    end
    else if (ee_ack)
    begin
      ee_ack <= 1'b0;
      ec <= 3'h0;
    end
    else if (ee_req && ec >= dly)
    begin
      ee_ack <= 1'b1;
      ee_count <= ee_count + 4'h1;
    end
    else
      ec <= ee_req ? ec + 3'h1 : 3'h0;
  end
  // Executor; code 03 fails, data outside an ack toggles so stale reads show
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_ack <= 1'b0;
      instr_err <= 1'b0;
      instr_rdata <= 16'h0000;
      ic <= 3'h0;
    end
    else if (!instr_ack && instr_req && ic >= dly)
    begin
      instr_ack <= 1'b1;
      instr_err <= instr_code == 8'h03;
      instr_rdata <= {8'h5a, instr_code};
    end
    else
    begin
      ic <= (instr_req && !instr_ack) ? ic + 3'h1 : 3'h0;
      instr_ack <= 1'b0;
      instr_err <= 1'b0;
      instr_rdata <= ~instr_rdata;
    end
  end
endmodule

// [tb/drc_top_tb.sv]
// Bench for the remote command handler, APB master tasks and checks.
// Assumes the core model answers the store and instruction ports.
`timescale 1ns/100ps
`include "drc_regs.svh"
module drc_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [5:0][15:0] mon = 0;
  logic [15:0] freq_cmd, torque_ram, instr_rdata, rnd = 16'h0605, sp, e;
  logic [15:0] ee_data, instr_data;
  logic pready, pslverr, ee_req, ee_ack, ee_sel, instr_req, instr_ack, instr_err;
  logic [7:0] instr_code, instr_ext;
  logic [3:0] ee_count;
  logic [2:0] dly = 3'h1;
  drc_pkg::drc_drive_t drive;
  int fails = 0, check_count = 0, cyc = 0, ins_n = 0;
  int slot[6] = '{2, 16, 18, 20, 22, 24};
  int mw[6] = '{0, 1, 4, 5, 6, 7};
  drc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mon_values(mon), .drive(drive), .freq_cmd(freq_cmd),
    .torque_ram(torque_ram), .ee_req(ee_req), .ee_sel(ee_sel), .ee_data(ee_data),
    .ee_ack(ee_ack), .instr_req(instr_req), .instr_code(instr_code),
    .instr_ext(instr_ext), .instr_data(instr_data),
    .instr_ack(instr_ack), .instr_err(instr_err), .instr_rdata(instr_rdata));
  drc_core_model core (.pclk(pclk), .presetn(presetn), .dly(dly), .ee_req(ee_req),
    .instr_req(instr_req), .instr_code(instr_code), .ee_ack(ee_ack), .ee_count(ee_count),
    .instr_ack(instr_ack), .instr_err(instr_err), .instr_rdata(instr_rdata));
  // ----------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------
  always #2.5 pclk = ~pclk;
  // A hung handshake ends the run here rather than stalling forever
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      results();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Each acked store carries the setpoint, then the torque word
  always @(posedge pclk)
  begin
    if (ee_req && ee_ack)
      cmp(ee_data, ee_sel ? ~rnd : sp);
  end
  // Each issued instruction carries its own code and data words
  always @(posedge pclk)
  begin
    if (instr_req && instr_ack)
    begin
      cmp({instr_ext, instr_code}, 16'(ins_n + 1));
      cmp(instr_data, 16'(ins_n + 16'h0a01));
      ins_n++;
    end
  end
  // Request held until pready is seen high; data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic stat(input logic [3:0] m, input logic [3:0] x);
    int n;
    n = 0;
    do begin apb(0, `DRC_A_STAT, 0); n++; end while ((rd[3:0] & m) !== x && n < 40);
    cmp({12'h0, rd[3:0] & m}, {12'h0, x});
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h0f0, 0);
    cmp({15'h0, err}, 16'h1);
    apb(1, `DRC_A_STAT, 16'hf);
    cmp({15'h0, err}, 16'h1);
    // Every run code under both shutoff polarities, random terminal bits
    for (int k = 0; k < 16; k++)
    begin
      rnd = lfsr(rnd);
      apb(1, `DRC_A_CFG, {15'h0, k[3]});
      apb(1, `DRC_A_CMD, {4'h0, rnd[11:2], k[1:0]});
      @(posedge pclk);
      #1 cmp({14'h0, drive.run}, k[1:0] == 1 ? 16'h1 : k[1:0] == 2 ? 16'h2 : 16'h0);
      e = {6'h0, rnd[2], rnd[3], rnd[4], rnd[5], rnd[6], rnd[7], rnd[8], rnd[9] ^ k[3],
        rnd[10], rnd[11]};
      cmp({6'h0, drive[9:0]}, e);
    end
    // Volatile write in vector control, then one setpoint change while held
    sp = rnd;
    apb(1, `DRC_A_CFG, 16'h0004);
    apb(1, `DRC_A_SETP, sp);
    apb(1, `DRC_A_TORQ, ~sp);
    apb(1, `DRC_A_CMD, 16'h2000);
    stat(4'h2, 4'h2);
    cmp(freq_cmd, sp);
    cmp(torque_ram, ~sp);
    sp = lfsr(sp);
    apb(1, `DRC_A_SETP, sp);
    repeat (2) @(posedge pclk);
    cmp(freq_cmd, sp);
    // Both setpoint bits rising together: only the volatile one runs
    apb(1, `DRC_A_CMD, 0);
    stat(4'h2, 4'h0);
    e = {12'h0, ee_count};
    apb(1, `DRC_A_CMD, 16'h6000);
    repeat (30) @(posedge pclk);
    apb(0, `DRC_A_STAT, 0);
    cmp({13'h0, rd[2:0]}, 16'h2);
    cmp({12'h0, ee_count}, e);
    apb(1, `DRC_A_CMD, 0);
    stat(4'h6, 4'h0);
    // Nonvolatile store, torque limit kept in profile 0, skipped in 24
    for (int i = 0; i < 2; i++)
    begin
      dly <= i ? 3'h4 : 3'h1;
      apb(1, `DRC_A_CFG, i ? 16'h1804 : 16'h0004);
      e = {12'h0, ee_count};
      apb(1, `DRC_A_CMD, 16'h4000);
      stat(4'h4, 4'h4);
      cmp({12'h0, ee_count} - e, i ? 16'h1 : 16'h2);
      cmp(freq_cmd, sp);
      apb(1, `DRC_A_CMD, 0);
      stat(4'h4, 4'h0);
    end
    // Six instruction slots, the third one fails
    for (int s = 0; s < 6; s++)
    begin
      apb(1, 12'(12'h100 + 4 * slot[s]), 16'(s + 1));
      apb(1, 12'(12'h104 + 4 * slot[s]), 16'(s + 16'h0a01));
    end
    apb(1, `DRC_A_CMD, 16'h8000);
    stat(4'h8, 4'h8);
    cmp(16'(ins_n), 16'h0006);
    for (int s = 0; s < 6; s++)
    begin
      apb(0, 12'(12'h200 + 4 * slot[s]), 0);
      cmp({15'h0, rd[15:0] !== 16'h0}, {15'h0, s == 2});
      apb(0, 12'(12'h204 + 4 * slot[s]), 0);
      cmp(rd[15:0], {8'h5a, 8'(s + 1)});
    end
    apb(1, `DRC_A_CMD, 0);
    stat(4'h8, 4'h0);
    // Monitor fill, then refresh with new values while held
    for (int j = 0; j < 2; j++)
    begin
      for (int k = 0; k < 6; k++) mon[k] <= lfsr(rnd + 16'(k * 7 + j));
      if (j == 0) apb(1, `DRC_A_CMD, 16'h1000);
      if (j == 0) stat(4'h1, 4'h1);
      repeat (20) @(posedge pclk);
      for (int k = 0; k < 6; k++)
      begin
        apb(0, 12'(12'h200 + 4 * mw[k]), 0);
        cmp(rd[15:0], mon[k]);
      end
    end
    apb(1, `DRC_A_CMD, 0);
    stat(4'h1, 4'h0);
    results();
  end
endmodule
